// >>> inc/dscl_pkg.sv
// Function
// - Host shifts 24-bit words MSB first on serial clock; load strobe rise latches them.
// - The two lowest word bits choose one of the four destination latches.
// - Select code 00 stores the word in the IF reference latch.
// - Select code 01 stores the word in the IF divider latch.
// - Reference latch: current 23..21, monitor 20..19, tristate 18, polarity 17, divide 16..2.
// - Divider latch: gain 23, power-down 22, prescaler 21..20, main 19..8, swallow 7..2.
// - Single-loop lock indication: monitor high with narrow low pulses while locked.
// - Combined lock indication shows lock only while both loops are locked.
// - Counter-reset modes hold counters and three-state the pump per section.
// - Releasing counter reset restarts both counters of a loop together.
// - Fast-acquire mode pulls the monitor pin to ground while fast acquisition runs.
// - Fast acquisition is active whenever the RF pump gain bit is one.
// - Power-down with pump driven first three-states the pump, then powers down.
// - IF power-down with pump already three-stated takes effect at the load.
// - RF power-down with pump already three-stated takes effect at the load.
// - Power-down holds that loop's counters loaded and its input stage high-impedance.
// - Reference oscillator input is disabled only while both power-down bits are set.
// - Shift register and latches keep loading during every power-down mode.
// - Loading a zero power-down bit restores the section immediately.
// - IF polarity bit selects phase-detector sense; host picks it from tuning slope.
// - IF tristate bit one three-states the IF charge pump; zero is normal.
// - Three current bits per section choose that charge-pump current setting.
// - Four monitor-select bits from both reference latches route the monitor pin.
package dscl_pkg;
  localparam int WORD_BITS = 24;
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_DIV = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_DIV = 2'h3;
  localparam int SEL_MSB   = 1;
  localparam int CUR_MSB   = 23;
  localparam int CUR_LSB   = 21;
  localparam int MON_HI    = 20;
  localparam int MON_LO    = 19;
  localparam int TRI_BIT   = 18;
  localparam int POL_BIT   = 17;
  localparam int RDIV_MSB  = 16;
  localparam int RDIV_LSB  = 2;
  localparam int GAIN_BIT  = 23;
  localparam int PD_BIT    = 22;
  localparam int PRE_HI    = 21;
  localparam int PRE_LO    = 20;
  localparam int MAIN_MSB  = 19;
  localparam int MAIN_LSB  = 8;
  localparam int SWAL_MSB  = 7;
  localparam int SWAL_LSB  = 2;
  localparam logic [23:0] LATCH_RESET = 24'h00_0000;
  localparam logic [6:0] MODULUS_BASE = 7'h08;
  // Monitor-select codes, ordered {rf_hi, rf_lo, if_hi, if_lo}.
  localparam logic [3:0] MON_LOW       = 4'h0;
  localparam logic [3:0] MON_IF_LOCK   = 4'h1;
  localparam logic [3:0] MON_RF_LOCK   = 4'h2;
  localparam logic [3:0] MON_BOTH_LOCK = 4'h3;
  localparam logic [3:0] MON_IF_RESET  = 4'h4;
  localparam logic [3:0] MON_RF_RESET  = 4'h5;
  localparam logic [3:0] MON_BOTH_RST  = 4'h6;
  localparam logic [3:0] MON_FAST      = 4'h7;
  localparam int CORE_PERIOD_PS = 25000;
  localparam int PD_SETTLE_NS = 100;
  localparam int PD_SETTLE_CYCLES =
    (PD_SETTLE_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int LOCK_PERIOD_NS = 1000;
  localparam int LOCK_PERIOD_CYCLES = (LOCK_PERIOD_NS * 1000) / CORE_PERIOD_PS;

  typedef struct packed {
    logic [2:0]  pump_current;
    logic [1:0]  monitor_sel;
    logic        pump_tristate;
    logic        pd_polarity;
    logic [14:0] reference_divide_value;
  } dscl_ref_t;

  typedef struct packed {
    logic        pump_gain;
    logic        powerdown_bit;
    logic [1:0]  prescale_sel;
    logic [11:0] main_count_value;
    logic [5:0]  swallow_count_value;
  } dscl_div_t;

  typedef struct packed {
    logic [14:0] reference_divide_value;
    logic [11:0] main_count_value;
    logic [5:0]  swallow_count_value;
    logic [6:0]  prescale_modulus;
    logic [2:0]  pump_current;
    logic        pd_polarity;
    logic        pump_gain;
    logic        pump_hiz;
    logic        counters_hold;
    logic        input_hiz;
    logic        powered_down;
  } dscl_loop_t;
endpackage

// >>> verilog/dscl_pd_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dscl_pd_seq
  import dscl_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic powerdown_bit,
  input  wire logic pump_tristate,
  output logic      pump_hiz,
  output logic      powered_down
);
  typedef enum logic [2:0] {
    PD_RUN    = 3'b001,
    PD_SETTLE = 3'b010,
    PD_DOWN   = 3'b100
  } dscl_pd_state_t;

  typedef struct packed {
    dscl_pd_state_t state;
    logic [7:0]     count;
  } dscl_pd_reg_t;

  dscl_pd_reg_t cur;
  dscl_pd_reg_t next_cur;

  always_comb begin
    next_cur = cur;
    unique case (cur.state)
      PD_RUN: begin
        if (powerdown_bit && pump_tristate) begin
          next_cur.state = PD_DOWN;
        end else if (powerdown_bit) begin
          next_cur.state = PD_SETTLE;
          next_cur.count = 8'(PD_SETTLE_CYCLES - 1);
        end
      end
      PD_SETTLE: begin
        if (!powerdown_bit) begin
          next_cur.state = PD_RUN;
        end else if (cur.count == 8'h00) begin
          next_cur.state = PD_DOWN;
        end else begin
          next_cur.count = cur.count - 8'h01;
        end
      end
      PD_DOWN: begin
        if (!powerdown_bit) begin
          next_cur.state = PD_RUN;
        end
      end
      default: next_cur.state = PD_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cur.state <= PD_RUN;
      cur.count <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // The pump is released only once the section is fully back in run.
  assign pump_hiz     = cur.state != PD_RUN;
  assign powered_down = cur.state == PD_DOWN;
endmodule // dscl_pd_seq
`default_nettype wire

// >>> verilog/dscl_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dscl_ctrl
  import dscl_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic serial_clk,
  input  wire logic serial_data,
  input  wire logic load_strobe,
  input  wire logic if_lock_detect,
  input  wire logic rf_lock_detect,
  output dscl_loop_t if_loop,
  output dscl_loop_t rf_loop,
  output logic       reference_osc_enable,
  output logic       monitor_output_pin,
  output logic       monitor_output_oe,
  output logic       damping_switch_pin
);

  function automatic dscl_ref_t decode_ref(input logic [23:0] word);
    dscl_ref_t f;
    f.pump_current           = word[CUR_MSB:CUR_LSB];
    f.monitor_sel            = word[MON_HI:MON_LO];
    f.pump_tristate          = word[TRI_BIT];
    f.pd_polarity            = word[POL_BIT];
    f.reference_divide_value = word[RDIV_MSB:RDIV_LSB];
    return f;
  endfunction

  function automatic dscl_div_t decode_div(input logic [23:0] word);
    dscl_div_t f;
    f.pump_gain           = word[GAIN_BIT];
    f.powerdown_bit       = word[PD_BIT];
    f.prescale_sel        = word[PRE_HI:PRE_LO];
    f.main_count_value    = word[MAIN_MSB:MAIN_LSB];
    f.swallow_count_value = word[SWAL_MSB:SWAL_LSB];
    return f;
  endfunction

  // Lower modulus of the dual-modulus pair; the upper one is this plus one.
  function automatic logic [6:0] prescale_modulus(input logic [1:0] sel);
    return MODULUS_BASE << sel;
  endfunction

  function automatic dscl_loop_t build_loop(
    input dscl_ref_t r,
    input dscl_div_t d,
    input logic      ctr_reset,
    input logic      seq_hiz,
    input logic      seq_down
  );
    dscl_loop_t l;
    l.reference_divide_value = r.reference_divide_value;
    l.main_count_value       = d.main_count_value;
    l.swallow_count_value    = d.swallow_count_value;
    l.prescale_modulus       = prescale_modulus(d.prescale_sel);
    l.pump_current           = r.pump_current;
    l.pd_polarity            = r.pd_polarity;
    l.pump_gain              = d.pump_gain;
    l.pump_hiz               = r.pump_tristate | ctr_reset | seq_hiz;
    // Both counters share one hold so they leave reset on the same edge.
    l.counters_hold          = ctr_reset | seq_down;
    l.input_hiz              = seq_down;
    l.powered_down           = seq_down;
    return l;
  endfunction

  // Link domain: only the shift register lives on the serial clock.
  typedef struct packed {
    logic [23:0] shift;
  } dscl_link_t;

  dscl_link_t link;
  dscl_link_t next_link;

  always_comb begin
    next_link = link;
    next_link.shift = {link.shift[22:0], serial_data};
  end

  // The serial clock stands still between words, so the shift register
  // carries no reset; its contents only matter once a load is seen.
  always_ff @(posedge serial_clk) begin
    link <= next_link;
  end

  typedef struct packed {
    logic             le_meta;
    logic             le_sync;
    logic             le_prev;
    logic             if_lock_meta;
    logic             if_lock_sync;
    logic             rf_lock_meta;
    logic             rf_lock_sync;
    logic [3:0][23:0] latch;
    logic [7:0]       pulse_count;
    logic             mon_out;
    logic             mon_oe;
    logic             damp;
  } dscl_core_t;

  dscl_core_t cur;
  dscl_core_t next_cur;

  logic        load_pulse;
  logic [1:0]  load_sel;
  dscl_ref_t   if_ref;
  dscl_ref_t   rf_ref;
  dscl_div_t   if_div;
  dscl_div_t   rf_div;
  logic [3:0]  mon_code;
  logic        if_ctr_reset;
  logic        rf_ctr_reset;
  logic        if_seq_hiz;
  logic        if_seq_down;
  logic        rf_seq_hiz;
  logic        rf_seq_down;
  logic        lock_gap;

  assign load_pulse = cur.le_sync & ~cur.le_prev;
  assign load_sel   = link.shift[SEL_MSB:0];
  assign if_ref     = decode_ref(cur.latch[SEL_IF_REF]);
  assign rf_ref     = decode_ref(cur.latch[SEL_RF_REF]);
  assign if_div     = decode_div(cur.latch[SEL_IF_DIV]);
  assign rf_div     = decode_div(cur.latch[SEL_RF_DIV]);
  assign mon_code   = {rf_ref.monitor_sel, if_ref.monitor_sel};
  assign lock_gap   = cur.pulse_count == 8'h00;

  assign if_ctr_reset = (mon_code == MON_IF_RESET) || (mon_code == MON_BOTH_RST);
  assign rf_ctr_reset = (mon_code == MON_RF_RESET) || (mon_code == MON_BOTH_RST);

  always_comb begin
    next_cur = cur;
    next_cur.le_meta      = load_strobe;
    next_cur.le_sync      = cur.le_meta;
    next_cur.le_prev      = cur.le_sync;
    next_cur.if_lock_meta = if_lock_detect;
    next_cur.if_lock_sync = cur.if_lock_meta;
    next_cur.rf_lock_meta = rf_lock_detect;
    next_cur.rf_lock_sync = cur.rf_lock_meta;

    // The word crosses as a quiet bus: the serial clock is idle once the
    // strobe rises, so the shift register is stable by the time the
    // synchronised edge arrives. Power-down never gates this path.
    if (load_pulse) begin
      next_cur.latch[load_sel] = link.shift;
    end

    if (lock_gap) begin
      next_cur.pulse_count = 8'(LOCK_PERIOD_CYCLES - 1);
    end else begin
      next_cur.pulse_count = cur.pulse_count - 8'h01;
    end

    next_cur.mon_oe = 1'b1;
    next_cur.mon_out = 1'b0;
    unique case (mon_code)
      MON_IF_LOCK: begin
        next_cur.mon_out = cur.if_lock_sync & ~lock_gap;
      end
      MON_RF_LOCK: begin
        next_cur.mon_out = cur.rf_lock_sync & ~lock_gap;
      end
      MON_BOTH_LOCK: begin
        next_cur.mon_out = cur.if_lock_sync & cur.rf_lock_sync & ~lock_gap;
      end
      MON_FAST: begin
        // Open-drain: pull to ground only while fast acquisition runs.
        next_cur.mon_oe = rf_div.pump_gain;
      end
      default: begin
        next_cur.mon_out = 1'b0;
      end
    endcase

    next_cur.damp = rf_div.pump_gain;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cur.le_meta      <= 1'b0;
      cur.le_sync      <= 1'b0;
      cur.le_prev      <= 1'b0;
      cur.if_lock_meta <= 1'b0;
      cur.if_lock_sync <= 1'b0;
      cur.rf_lock_meta <= 1'b0;
      cur.rf_lock_sync <= 1'b0;
      cur.latch        <= {4{LATCH_RESET}};
      cur.pulse_count  <= 8'h00;
      cur.mon_out      <= 1'b0;
      cur.mon_oe       <= 1'b1;
      cur.damp         <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  dscl_pd_seq u_if_pd (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .powerdown_bit (if_div.powerdown_bit),
    .pump_tristate (if_ref.pump_tristate),
    .pump_hiz      (if_seq_hiz),
    .powered_down  (if_seq_down)
  );

  dscl_pd_seq u_rf_pd (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .powerdown_bit (rf_div.powerdown_bit),
    .pump_tristate (rf_ref.pump_tristate),
    .pump_hiz      (rf_seq_hiz),
    .powered_down  (rf_seq_down)
  );

  assign if_loop = build_loop(if_ref, if_div, if_ctr_reset, if_seq_hiz, if_seq_down);
  assign rf_loop = build_loop(rf_ref, rf_div, rf_ctr_reset, rf_seq_hiz, rf_seq_down);

  // Follows the latched bits, not the sequencers, so a synchronous
  // power-down keeps the reference alive until software asks for both.
  assign reference_osc_enable = ~(if_div.powerdown_bit & rf_div.powerdown_bit);

  assign monitor_output_pin = cur.mon_out;
  assign monitor_output_oe  = cur.mon_oe;
  assign damping_switch_pin = cur.damp;
endmodule // dscl_ctrl
`default_nettype wire

// >>> bench/dscl_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dscl_ctrl_checker
  import dscl_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire dscl_loop_t if_loop,
  input wire dscl_loop_t rf_loop,
  input wire logic       reference_osc_enable,
  input wire logic       damping_switch_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_if_pd_hold: assert property (
    if_loop.powered_down |-> if_loop.counters_hold && if_loop.input_hiz && if_loop.pump_hiz)
    else $error("IF powered down without counters held and input idle");
  chk_rf_pd_hold: assert property (
    rf_loop.powered_down |-> rf_loop.counters_hold && rf_loop.input_hiz && rf_loop.pump_hiz)
    else $error("RF powered down without counters held and input idle");
  chk_if_pump_first: assert property (
    $rose(if_loop.powered_down) |-> $past(if_loop.pump_hiz))
    else $error("IF powered down before its pump was idle");
  chk_rf_pump_first: assert property (
    $rose(rf_loop.powered_down) |-> $past(rf_loop.pump_hiz))
    else $error("RF powered down before its pump was idle");
  chk_osc_off_both: assert property (
    $fell(reference_osc_enable) |-> ##[1:6] (if_loop.powered_down && rf_loop.powered_down))
    else $error("Reference input off without both loops down");
  chk_osc_on_again: assert property (
    $rose(reference_osc_enable) |=> !(if_loop.powered_down && rf_loop.powered_down))
    else $error("Loops stayed down after reference input returned");
  chk_if_wake_input: assert property (
    $fell(if_loop.powered_down) |-> !if_loop.input_hiz)
    else $error("IF input stage still idle after wake");
  chk_damp_follow: assert property (
    damping_switch_pin == $past(rf_loop.pump_gain))
    else $error("Damping switch does not follow RF gain");
  chk_modulus_set: assert property (
    if_loop.prescale_modulus inside {7'h08, 7'h10, 7'h20, 7'h40})
    else $error("IF prescaler modulus outside the four settings");
endmodule // dscl_ctrl_checker
bind dscl_ctrl dscl_ctrl_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .if_loop(if_loop), .rf_loop(rf_loop), .reference_osc_enable(reference_osc_enable),
  .damping_switch_pin(damping_switch_pin));
`default_nettype wire

// >>> bench/dscl_host.sv
`timescale 1ns/1ps
`default_nettype none
module dscl_host (
  input  wire logic core_clk,
  output logic      serial_clk = 1'b0,
  output logic      serial_data = 1'b0,
  output logic      load_strobe = 1'b0
);
  // The link clock runs only inside a word, at a 6 ns period, off the core phase.
  task automatic send(input logic [23:0] word);
    #1.7;
    for (int i = 23; i >= 0; i--) begin
      serial_data = word[i];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    // Released data shows the inverse so a stale bit cannot pass as valid.
    serial_data = ~word[0];
    @(posedge core_clk);
    load_strobe <= 1'b1;
    repeat (3) @(posedge core_clk);
    load_strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
endmodule // dscl_host
`default_nettype wire

// >>> bench/dscl_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dscl_ctrl_tb_top
  import dscl_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       if_lock_detect = 1'b0;
  logic       rf_lock_detect = 1'b0;
  wire logic  serial_clk, serial_data, load_strobe, osc_en, mon_pin, mon_oe, damp;
  dscl_loop_t if_loop, rf_loop;
  int         mismatches = 0;
  int         checks_done = 0;
  int         n;
  logic [4:0] lk [7] = '{5'h13, 5'h10, 5'h17, 5'h1C, 5'h1F, 5'h02, 5'h0D};

  always #12.5 core_clk = ~core_clk;

  dscl_host host (.core_clk(core_clk), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe(load_strobe));
  dscl_ctrl dut (.core_clk(core_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe), .if_lock_detect(if_lock_detect),
    .rf_lock_detect(rf_lock_detect), .if_loop(if_loop), .rf_loop(rf_loop),
    .reference_osc_enable(osc_en), .monitor_output_pin(mon_pin),
    .monitor_output_oe(mon_oe), .damping_switch_pin(damp));

  function automatic logic [23:0] ref_w(logic [2:0] c, logic [1:0] m, logic t, logic p,
                                        logic [14:0] d, logic rf);
    return {c, m, t, p, d, rf, 1'b0};
  endfunction
  function automatic logic [23:0] div_w(logic g, logic pd, logic [1:0] pre, logic [11:0] b,
                                        logic [5:0] a, logic rf);
    return {g, pd, pre, b, a, rf, 1'b1};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic set_mon(input logic [3:0] c);
    host.send(ref_w(3'h0, c[1:0], 1'b0, 1'b1, 15'h0010, 1'b0));
    host.send(ref_w(3'h0, c[3:2], 1'b0, 1'b1, 15'h0010, 1'b1));
  endtask
  task automatic count_high();
    n = 0;
    repeat (48) begin
      @(negedge core_clk);
      n += int'(mon_pin === 1'b1);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge core_clk);
    check({if_loop.prescale_modulus, osc_en, damp, mon_oe, mon_pin}, 24'h00_008A);
    // Decode of both reference latches; the other latch must stay untouched.
    host.send(ref_w(3'h5, 2'h0, 1'b1, 1'b1, 15'h4B2D, 1'b0));
    check({if_loop.pump_current, if_loop.pd_polarity, if_loop.pump_hiz}, 24'h00_0017);
    check(if_loop.reference_divide_value, 24'h00_4B2D);
    host.send(ref_w(3'h2, 2'h0, 1'b0, 1'b0, 15'h7FFF, 1'b1));
    check({rf_loop.pump_current, rf_loop.pd_polarity, rf_loop.pump_hiz}, 24'h00_0008);
    check(rf_loop.reference_divide_value, 24'h00_7FFF);
    check(if_loop.reference_divide_value, 24'h00_4B2D);
    $display("test reference latches done");
    for (int i = 0; i < 4; i++) begin
      host.send(div_w(i[0], 1'b0, 2'(i), 12'hA5C + 12'(i), 6'h2A ^ 6'(i), 1'b0));
      host.send(div_w(i[1], 1'b0, 2'(3 - i), 12'hFFF - 12'(i), 6'(i), 1'b1));
      check(if_loop.prescale_modulus, 24'(7'h08 << i));
      check(rf_loop.prescale_modulus, 24'(7'h08 << (3 - i)));
      check({if_loop.main_count_value, if_loop.swallow_count_value},
            {12'hA5C + 12'(i), 6'h2A ^ 6'(i)});
      check({rf_loop.main_count_value, rf_loop.swallow_count_value},
            {12'hFFF - 12'(i), 6'(i)});
      check({if_loop.pump_gain, rf_loop.pump_gain, damp}, {21'h0, i[0], i[1], i[1]});
    end
    $display("test divider latches done");
    host.send(div_w(1'b0, 1'b1, 2'h1, 12'h010, 6'h01, 1'b1));
    check({rf_loop.pump_hiz, rf_loop.powered_down}, 24'h00_0002);
    repeat (PD_SETTLE_CYCLES + 1) @(negedge core_clk);
    check({rf_loop.powered_down, rf_loop.counters_hold, rf_loop.input_hiz}, 24'h00_0007);
    check(osc_en, 24'h00_0001);
    host.send(div_w(1'b0, 1'b1, 2'h0, 12'h010, 6'h01, 1'b0));
    check({if_loop.powered_down, if_loop.input_hiz, osc_en}, 24'h00_0006);
    host.send(ref_w(3'h1, 2'h0, 1'b0, 1'b0, 15'h1234, 1'b1));
    check(rf_loop.reference_divide_value, 24'h00_1234);
    host.send(div_w(1'b0, 1'b0, 2'h0, 12'h010, 6'h01, 1'b1));
    check({rf_loop.powered_down, rf_loop.input_hiz, osc_en}, 24'h00_0001);
    host.send(div_w(1'b0, 1'b0, 2'h0, 12'h010, 6'h01, 1'b0));
    check({if_loop.powered_down, if_loop.counters_hold}, 24'h00_0000);
    $display("test power-down done");
    // Each entry: select code, IF lock, RF lock, whether the pin shows lock.
    foreach (lk[k]) begin
      set_mon({2'b00, lk[k][4:3]});
      if_lock_detect <= lk[k][2];
      rf_lock_detect <= lk[k][1];
      repeat (6) @(negedge core_clk);
      count_high();
      check({23'h0, lk[k][0] ? (n == 46 || n == 47) : (n == 0)}, 24'h00_0001);
    end
    for (int c = 4; c < 7; c++) begin
      set_mon(4'(c));
      check({if_loop.counters_hold, if_loop.pump_hiz}, {22'h0, {2{c != 5}}});
      check({rf_loop.counters_hold, rf_loop.pump_hiz, mon_pin}, {21'h0, {2{c != 4}}, 1'b0});
    end
    set_mon(4'h0);
    check({if_loop.counters_hold, rf_loop.counters_hold}, 24'h00_0000);
    host.send(div_w(1'b1, 1'b0, 2'h0, 12'h010, 6'h01, 1'b1));
    set_mon(4'h7);
    check({mon_oe, mon_pin, damp}, 24'h00_0005);
    host.send(div_w(1'b0, 1'b0, 2'h0, 12'h010, 6'h01, 1'b1));
    check({mon_oe, damp}, 24'h00_0000);
    $display("test monitor modes done");
    test_done();
  end
endmodule // dscl_ctrl_tb_top
`default_nettype wire
